/* ccw_pkg.sv */
// ccw_pkg: register map, field positions and reset values of the
// comparator control and wake-up block.
// assumes a byte-wide register port with one-cycle read latency.
package ccw_pkg;
  // register offsets
  localparam logic [7:0] CCW_A_SMALL_OFS = 8'h07;
  localparam logic [7:0] CCW_A_LARGE_OFS = 8'h08;
  localparam logic [7:0] CCW_B_OFS = 8'h0b;
  localparam logic [7:0] CCW_WAKE_OFS = 8'h0d;
  // field positions inside a control register
  localparam int CCW_RESULT_BIT = 7;
  localparam int CCW_PIN_DRIVE_N_BIT = 6;
  localparam int CCW_INVERT_N_BIT = 5;
  localparam int CCW_TIMER_SRC_N_BIT = 4;
  localparam int CCW_ALT_SEL_BIT = 4;
  localparam int CCW_ENABLE_BIT = 3;
  localparam int CCW_NEG_SEL_BIT = 2;
  localparam int CCW_POS_SEL_BIT = 1;
  localparam int CCW_WAKE_DIS_BIT = 0;
  // wake flag position in its own register
  localparam int CCW_WAKE_FLAG_BIT = 0;
  // power-on value of every control register
  localparam logic [7:0] CCW_CTRL_RESET = 8'hff;
  // positive input choice codes for the analog mux
  localparam logic [1:0] CCW_POS_OWN_POS = 2'h0;
  localparam logic [1:0] CCW_POS_OWN_NEG = 2'h1;
  localparam logic [1:0] CCW_POS_A_POS = 2'h2;
endpackage

/* ccw_top.sv */
// ccw_top: control registers, output routing, timer source choice
// and wake-on-change detection for up to two comparators.
// assumes the analog cores, timer and pin drivers sit outside and
// that all inputs but ARST_N are synchronous to CLOCK.
`timescale 1ns/1ps

module ccw_top
  import ccw_pkg::*;
#(
  parameter int NUM_CMP = 2,
  parameter logic [7:0] CMP_A_OFS = CCW_A_LARGE_OFS
) (
  input wire logic CLOCK, // core clock
  input wire logic ARST_N, // asynchronous reset, active low
  input wire logic CE, // clock enable, freezes all state when low
  input wire logic [7:0] ADDR, // register address
  input wire logic [7:0] WDATA, // register write data
  input wire logic WR, // write strobe
  input wire logic RD, // read strobe
  output logic [7:0] RDATA, // read data, cycle after RD
  input wire logic SLEEP, // device is sleeping
  input wire logic [1:0] CMP_RAW, // raw analog comparator outputs
  input wire logic TIMER_CLOCK_SELECT, // timer counter-mode select
  input wire logic TIMER_PIN_IN, // count pin level from pad
  output logic [1:0] CMP_POWER, // analog core power on
  output logic [1:0] CMP_NEG_PIN, // negative: 1 pin, 0 reference
  output logic [1:0] CMP_POS_OWN, // positive from own positive pin
  output logic CMP_B_POS_A, // second positive from first's pin
  output logic [1:0] CMP_PIN_OUT, // result level for output pins
  output logic [1:0] CMP_PIN_OE, // result drives output pin
  output logic [1:0] CMP_ANALOG, // pins held in analog mode
  output logic TIMER_COUNT_IN, // timer count input
  output logic TIMER_PIN_OVERRIDE, // comparator owns timer pin dir
  output logic WAKE_FLAG, // comparator wake flag
  output logic WAKE_REQ // wake request to core
);

  // elaboration checks: the storage and pin map serve one or two cores,
  // and the first core sits at one of its two known offsets only
  if (NUM_CMP < 1 || NUM_CMP > 2) begin : g_bad_count
    $error("NUM_CMP must be 1 or 2");
  end
  localparam bit OFS_OK = (CMP_A_OFS == CCW_A_SMALL_OFS) ||
    (CMP_A_OFS == CCW_A_LARGE_OFS);
  if (!OFS_OK) begin : g_bad_offset
    $error("CMP_A_OFS must be one of the two control offsets");
  end

  ////////////////////////////////////////////////////////////////////
  // storage
  logic [6:0] ctrl [2]; // writable fields, bits 6..0
  logic [1:0] shadow; // result latched on a control read
  logic [1:0] armed; // a latching read has happened
  logic wake;
  logic [7:0] rdata;
  logic [6:0] next_ctrl [2]; // control fields for the next edge
  logic [1:0] next_shadow; // shadow for the next edge
  logic [1:0] next_armed; // armed marks for the next edge

  ////////////////////////////////////////////////////////////////////
  // decode
  wire hit_a = (ADDR == CMP_A_OFS);
  wire hit_b = (ADDR == CCW_B_OFS) && (NUM_CMP == 2);
  wire hit_w = (ADDR == CCW_WAKE_OFS);
  wire [1:0] hit = {hit_b, hit_a};
  wire [1:0] rd_ctrl = hit & {2{RD}};
  wire [1:0] wr_ctrl = hit & {2{WR}};

  logic [1:0] result; // polarity-adjusted result
  logic [1:0] enabled;
  logic [1:0] change;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cmp
      // live result; zero when off or absent
      wire present = (g < NUM_CMP);
      assign enabled[g] = present && ctrl[g][CCW_ENABLE_BIT];
      // raw is high when positive input is above negative
      assign result[g] = enabled[g] &&
        (CMP_RAW[g] ~^ ctrl[g][CCW_INVERT_N_BIT]);
      assign CMP_POWER[g] = enabled[g];
      assign CMP_NEG_PIN[g] =
        enabled[g] && ctrl[g][CCW_NEG_SEL_BIT];
      assign CMP_POS_OWN[g] =
        enabled[g] && ctrl[g][CCW_POS_SEL_BIT];
      assign CMP_PIN_OUT[g] = result[g];
      assign CMP_PIN_OE[g] =
        enabled[g] && !ctrl[g][CCW_PIN_DRIVE_N_BIT];
      // reset leaves every field one: inputs stay analog
      assign CMP_ANALOG[g] = present && ctrl[g] == CCW_CTRL_RESET[6:0];
      // change against shadow only counts once armed and enabled
      assign change[g] = armed[g] && enabled[g] &&
        !ctrl[g][CCW_WAKE_DIS_BIT] && (result[g] != shadow[g]);

      // control fields; result bit is not stored, so writes miss it
      assign next_ctrl[g] = (CE && wr_ctrl[g]) ? WDATA[6:0] : ctrl[g];
      // a control read latches the last known result
      assign next_shadow[g] =
        (CE && rd_ctrl[g]) ? result[g] : shadow[g];
      assign next_armed[g] = armed[g] || (CE && rd_ctrl[g]);
    end
  endgenerate

  // one process owns all per-comparator storage, so no bit of it has
  // two writers
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < 2; i++) begin
        ctrl[i] <= CCW_CTRL_RESET[6:0];
      end
      shadow <= 2'h0;
      armed <= 2'h0;
    end else begin
      ctrl <= next_ctrl;
      shadow <= next_shadow;
      armed <= next_armed;
    end
  end

  // second comparator alternate positive source, only when own off
  assign CMP_B_POS_A = (NUM_CMP == 2) && enabled[1] &&
    !ctrl[1][CCW_POS_SEL_BIT] && ctrl[1][CCW_ALT_SEL_BIT];

  ////////////////////////////////////////////////////////////////////
  // timer source: comparator output replaces the pin when selected
  wire cmp_timer = enabled[0] && !ctrl[0][CCW_TIMER_SRC_N_BIT];
  assign TIMER_COUNT_IN = (TIMER_CLOCK_SELECT && cmp_timer) ?
    result[0] : TIMER_PIN_IN;
  // pin drive wins over the timer select for pin direction
  assign TIMER_PIN_OVERRIDE = CMP_PIN_OE[0];

  ////////////////////////////////////////////////////////////////////
  // wake flag: set wins over a clearing write in the same cycle
  wire wake_set = SLEEP && (|change);
  wire wake_clr = WR && hit_w && !WDATA[CCW_WAKE_FLAG_BIT];
  wire next_wake = wake_set || (wake && !wake_clr);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake <= 1'b0;
    end else if (CE) begin
      wake <= next_wake;
    end
  end

  assign WAKE_FLAG = wake;
  assign WAKE_REQ = wake && SLEEP;

  ////////////////////////////////////////////////////////////////////
  // read data mux; unmapped addresses read zero
  wire [7:0] rd_a = {result[0], ctrl[0]};
  wire [7:0] rd_b = {result[1], ctrl[1]};
  wire [7:0] rd_w = {7'h00, wake};
  wire [7:0] next_rdata = hit_a ? rd_a : hit_b ? rd_b :
    hit_w ? rd_w : 8'h00;

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata <= 8'h00;
    end else if (CE) begin
      rdata <= RD ? next_rdata : 8'h00;
    end
  end

  assign RDATA = rdata;

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_latch_read;
    CE && rd_ctrl[0];
  endsequence
  sequence s_latch_read_b;
    CE && rd_ctrl[1];
  endsequence
  sequence s_wake_cause_b;
    CE && SLEEP && change[1];
  endsequence

  a_wake_set_cause: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CE && SLEEP && change[0] |=> wake)
    else $error("wake flag not set on change in sleep");

  a_wake_needs_sleep: assert property (@(posedge CLOCK)
    disable iff (!ARST_N)
    CE && !wake && !wake_set |=> !wake)
    else $error("wake flag rose without cause");

  a_wake_clear: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    CE && wake && wake_clr && !wake_set |=> !wake)
    else $error("wake flag not cleared by write");

  a_result_read_only: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && RD && hit_a |=> RDATA[CCW_RESULT_BIT] == $past(result[0]))
    else $error("result bit follows written data");

  a_pin_drive_level: assert property (@(posedge CLOCK)
    disable iff (!ARST_N)
    CMP_PIN_OE[0] |-> enabled[0] && !ctrl[0][CCW_PIN_DRIVE_N_BIT])
    else $error("pin driven while drive disabled");

  a_polarity_pass: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[0] && ctrl[0][CCW_INVERT_N_BIT] |-> result[0] == CMP_RAW[0])
    else $error("polarity one does not pass output");

  a_timer_source: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    TIMER_CLOCK_SELECT && enabled[0] && !ctrl[0][CCW_TIMER_SRC_N_BIT]
    |-> TIMER_COUNT_IN == result[0])
    else $error("comparator not routed to timer");

  a_off_no_control: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    !enabled[0] |-> !CMP_PIN_OE[0] && !CMP_NEG_PIN[0] && !CMP_POWER[0])
    else $error("fields act while comparator off");

  a_latch_shadow: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    s_latch_read |=> armed[0] && shadow[0] == $past(result[0]))
    else $error("read did not latch result");

  a_neg_select: assert property (@(posedge CLOCK) disable iff (!ARST_N)
    enabled[1] |-> CMP_NEG_PIN[1] == ctrl[1][CCW_NEG_SEL_BIT])
    else $error("negative select wrong");

  // the analog core is powered exactly when its field says on
  a_power_follows: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CMP_POWER[0] == ctrl[0][CCW_ENABLE_BIT])
    else $error("power does not follow enable field");

  // second core never drives its pin with the drive field set
  a_pin_drive_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CMP_PIN_OE[1] |-> enabled[1] && !ctrl[1][CCW_PIN_DRIVE_N_BIT])
    else $error("second pin driven while drive disabled");

  // a cleared polarity field inverts the raw level
  a_polarity_invert: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[0] && !ctrl[0][CCW_INVERT_N_BIT] |-> result[0] != CMP_RAW[0])
    else $error("polarity zero does not invert output");

  // polarity one passes the raw level on the second core too
  a_polarity_pass_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[1] && ctrl[1][CCW_INVERT_N_BIT] |-> result[1] == CMP_RAW[1])
    else $error("second polarity one does not pass output");

  // an off core shows a quiet low level, not a chattering one
  a_off_pin_low: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    !enabled[0] |-> !CMP_PIN_OUT[0] && !CMP_POS_OWN[0])
    else $error("off comparator still drives its level");

  // without counter mode the timer always sees its own pin
  a_timer_pin: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    !TIMER_CLOCK_SELECT |-> TIMER_COUNT_IN == TIMER_PIN_IN)
    else $error("timer input not from pin");

  // source field one keeps the timer on its own pin, whatever the timer select
  a_timer_own_select: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    ctrl[0][CCW_TIMER_SRC_N_BIT] |-> TIMER_COUNT_IN == TIMER_PIN_IN)
    else $error("comparator took timer while source field one");

  // first positive input follows its select while on
  a_pos_select_a: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[0] |-> CMP_POS_OWN[0] == ctrl[0][CCW_POS_SEL_BIT])
    else $error("first positive select wrong");

  // second positive select one picks its own pin only
  a_pos_select_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[1] && ctrl[1][CCW_POS_SEL_BIT] |-> CMP_POS_OWN[1] && !CMP_B_POS_A)
    else $error("second positive own pin not chosen");

  // at zero the alternate field picks the first core's pin
  a_alt_select_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    enabled[1] && !ctrl[1][CCW_POS_SEL_BIT] |->
      CMP_B_POS_A == ctrl[1][CCW_ALT_SEL_BIT])
    else $error("second positive alternate choice wrong");

  // with both wake fields set nothing may raise the flag
  a_wake_disabled: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && !wake && ctrl[0][CCW_WAKE_DIS_BIT] && ctrl[1][CCW_WAKE_DIS_BIT]
      |=> !wake)
    else $error("wake flag set while wake disabled");

  // the flag holds until cleared by software
  a_wake_hold: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && wake && !wake_clr |=> wake)
    else $error("wake flag dropped without a clear");

  // a change in sleep on the second core also raises the flag
  a_wake_set_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    s_wake_cause_b |=> wake)
    else $error("wake flag not set on second change in sleep");

  // a second-core read latches its own result
  a_latch_shadow_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    s_latch_read_b |=> armed[1] && shadow[1] == $past(result[1]))
    else $error("second read did not latch result");

  // a control write lands in the writable fields only
  a_ctrl_write: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && wr_ctrl[0] |=> ctrl[0] == $past(WDATA[6:0]))
    else $error("control write did not land");

  // second result bit reads the live level
  a_rdata_result_b: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && RD && hit_b |=> RDATA[CCW_RESULT_BIT] == $past(result[1]))
    else $error("second result bit wrong on read");

  // read data stands one cycle only, then returns to zero
  a_rdata_idle: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    CE && !RD |=> RDATA == 8'h00)
    else $error("read data stands without a read");

  // a low clock enable freezes every stored bit
  a_clock_freeze: assert property (
    @(posedge CLOCK) disable iff (!ARST_N)
    !CE |=> $stable(ctrl[0]) && $stable(wake) && $stable(RDATA))
    else $error("state moved while clock enable low");

endmodule

/* ccw_far.sv */
// ccw_far: behavioural pair of analog comparator cores for the bench.
// assumes the bench sets the wanted pos>neg outcome on LEVEL.
`timescale 1ns/1ps
module ccw_far (
  input wire logic CLOCK, // core clock
  input wire logic [1:0] POWER, // core power from the block
  input wire logic [1:0] LEVEL, // 1 when positive exceeds negative
  output logic [1:0] RAW // comparator outputs
);
  logic [1:0] q = 2'h0;
  // one cycle of settling; an unpowered core chatters, never holds
  always @(posedge CLOCK) begin
    for (int i = 0; i < 2; i++) begin
      q[i] <= POWER[i] ? LEVEL[i] : ~q[i];
    end
  end
  assign RAW = q;
endmodule

/* testbench.sv */
// testbench: random and corner register traffic plus wake scenarios.
// assumes ccw_top with its default first-comparator offset.
`timescale 1ns/1ps
module testbench;
  import ccw_pkg::*;
  logic CLOCK = 0, ARST_N = 0, WR = 0, RD = 0, SLEEP = 0, ce = 1;
  logic tcs = 0, tpin = 0;
  logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, a, b, d;
  logic [1:0] lvl = 2'h3, raw, pwr, negp, posp, pout, poe, ana;
  logic bpa, tin, tov, WAKE_FLAG, WAKE_REQ;
  int n_tests = 0, n_mismatch = 0, seed = 32'h4e45;
  wire logic [14:0] obs = {pwr, negp, posp, bpa, pout, poe, tin, tov,
    WAKE_FLAG, WAKE_REQ};
  always #2 CLOCK = ~CLOCK;
  ccw_top dut_u (.CLOCK(CLOCK), .ARST_N(ARST_N), .CE(ce), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SLEEP(SLEEP),
    .CMP_RAW(raw), .TIMER_CLOCK_SELECT(tcs), .TIMER_PIN_IN(tpin),
    .CMP_POWER(pwr), .CMP_NEG_PIN(negp), .CMP_POS_OWN(posp),
    .CMP_B_POS_A(bpa), .CMP_PIN_OUT(pout), .CMP_PIN_OE(poe),
    .CMP_ANALOG(ana), .TIMER_COUNT_IN(tin), .TIMER_PIN_OVERRIDE(tov),
    .WAKE_FLAG(WAKE_FLAG), .WAKE_REQ(WAKE_REQ));
  ccw_far far_u (.CLOCK(CLOCK), .POWER(pwr), .LEVEL(lvl), .RAW(raw));
  ////////////////////////////////////////////////////////////////////////
  // expected result bit: zero while off, polarity applied while on
  function automatic logic res(input logic [7:0] r, input logic l);
    return r[3] & (r[5] ? l : ~l);
  endfunction
  // expected output pins from the two control values
  function automatic logic [14:0] exp_out(input logic [7:0] x, y,
    input logic [1:0] l, input logic f);
    logic [1:0] p, o;
    p = {res(y, l[1]), res(x, l[0])};
    o = {y[3] & ~y[6], x[3] & ~x[6]};
    return {y[3], x[3], y[3] & y[2], x[3] & x[2], y[3] & y[1], x[3] & x[1],
      y[3] & ~y[1] & y[4], p, o, (tcs & ~x[4] & x[3]) ? p[0] : tpin, o[0],
      f, f & SLEEP};
  endfunction
  task automatic check(input logic [14:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ad, v);
    @(posedge CLOCK);
    ADDR <= ad;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [7:0] v);
    @(posedge CLOCK);
    ADDR <= ad;
    RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 v = RDATA;
  endtask
  task final_report;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog well beyond the few hundred cycles the run needs
  initial begin
    #100000;
    n_mismatch++;
    final_report;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge CLOCK);
    ARST_N <= 1'b1;
    @(posedge CLOCK);
    #1 check(obs, exp_out(8'hff, 8'hff, lvl, 1'b0));
    check({13'h0, ana}, 15'h0003);
    rd(CCW_A_LARGE_OFS, d);
    check({7'h0, d}, {7'h0, res(8'hff, lvl[0]), 7'h7f});
    // read data must be gone one cycle later
    @(posedge CLOCK);
    #1 check({7'h0, RDATA}, 15'h0000);
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 8'h08 : 8'($random(seed));
      b = (i == 0) ? 8'h18 : 8'($random(seed));
      @(posedge CLOCK);
      lvl <= 2'($random(seed));
      tcs <= 1'($random(seed));
      tpin <= 1'($random(seed));
      wr(CCW_A_LARGE_OFS, a);
      wr(CCW_B_OFS, b);
      // settling time after new inputs
      repeat (2) @(posedge CLOCK);
      #1 check(obs, exp_out(a, b, lvl, 1'b0));
      check({13'h0, ana}, {13'h0, &b[6:0], &a[6:0]});
      rd(CCW_A_LARGE_OFS, d);
      check({7'h0, d}, {7'h0, res(a, lvl[0]), a[6:0]});
      rd(CCW_B_OFS, d);
      check({7'h0, d}, {7'h0, res(b, lvl[1]), b[6:0]});
    end
    // unmapped place ignores writes and reads as zero
    wr(8'h20, 8'h55);
    rd(8'h20, d);
    check({7'h0, d}, 15'h0000);
    // wake on change, disabled first and then enabled
    for (int w = 1; w >= 0; w--) begin
      @(posedge CLOCK);
      lvl <= 2'h0;
      wr(CCW_B_OFS, 8'hf7);
      wr(CCW_A_LARGE_OFS, {7'h7f, w[0]});
      repeat (2) @(posedge CLOCK);
      rd(CCW_A_LARGE_OFS, d);
      @(posedge CLOCK);
      SLEEP <= 1'b1;
      repeat (2) @(posedge CLOCK);
      #1 check({14'h0, WAKE_FLAG}, 15'h0000);
      @(posedge CLOCK);
      lvl <= 2'h1;
      repeat (3) @(posedge CLOCK);
      #1 check(obs, exp_out({7'h7f, w[0]}, 8'hf7, 2'h1, !w));
      @(posedge CLOCK);
      SLEEP <= 1'b0;
      wr(CCW_WAKE_OFS, 8'h00);
      rd(CCW_WAKE_OFS, d);
      check({7'h0, d}, 15'h0000);
    end
    // a low clock enable makes a write miss the register
    @(posedge CLOCK);
    ce <= 1'b0;
    wr(CCW_A_LARGE_OFS, 8'h00);
    ce <= 1'b1;
    rd(CCW_A_LARGE_OFS, d);
    check({7'h0, d}, {7'h0, res(8'hfe, lvl[0]), 7'h7e});
    // a second reset in mid-run restores every field
    @(posedge CLOCK);
    ARST_N <= 1'b0;
    @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLOCK);
    #1 check(obs, exp_out(8'hff, 8'hff, lvl, 1'b0));
    check({13'h0, ana}, 15'h0003);
    final_report;
  end
endmodule
